// >>> src/lcpf_defines.svh
// register offsets, field positions, reset values and limits of the load-cell post filter
// assumes a 32-bit apb slave with byte addresses on an 8-bit paddr
`ifndef LCPF_DEFINES_SVH
`define LCPF_DEFINES_SVH

`define LCPF_ADDR_CTRL      8'h00
`define LCPF_ADDR_TAPS      8'h04
`define LCPF_ADDR_STATUS    8'h08
`define LCPF_ADDR_IRQ_EN    8'h0c
`define LCPF_ADDR_IRQ_CLR   8'h10
`define LCPF_PAGE_THR       4'h2
`define LCPF_PAGE_PORT      4'h3

`define LCPF_CTRL_RATE_LSB  0
`define LCPF_CTRL_AZ_BIT    4
`define LCPF_CTRL_EXC_BIT   5
`define LCPF_TAP_FIELD_W    4

`define LCPF_TAP_MAX        4'ha
`define LCPF_FRAC_BITS      10
`define LCPF_RST_RATE       4'h8
`define LCPF_RST_TAPS       16'h0000

`define LCPF_WORD_FLUSH_BIT 1
`define LCPF_WORD_FRESH_BIT 0

// default flush thresholds in adc counts, index is the rate code
`define LCPF_THR_R0         24'h00010c
`define LCPF_THR_R1         24'h0000b0
`define LCPF_THR_R2         24'h0000bc
`define LCPF_THR_R3         24'h000068
`define LCPF_THR_R4         24'h00005a
`define LCPF_THR_R5         24'h000038
`define LCPF_THR_R6         24'h00002e
`define LCPF_THR_R7         24'h000016
`define LCPF_THR_R8         24'h000010
`define LCPF_THR_R9         24'h00000e
`define LCPF_THR_R10        24'h00000c
`define LCPF_THR_R11        24'h00000a
`define LCPF_THR_LOW        24'h000008

`endif

// >>> src/lcpf_pkg.sv
// types shared by the load-cell post filter
// writes its widths out by hand; they match the figures in lcpf_defines.svh, which it does not include
package lcpf_pkg;

    typedef logic [3:0]  lcpf_tap_t;
    typedef logic [23:0] lcpf_sample_t;

    typedef struct packed {
        logic [3:0][33:0]    acc;
        logic [3:0]          az_phase;
        logic [3:0]          rate;
        logic                az_en;
        logic                exc_high;
        logic [3:0][3:0]     taps;
        logic [3:0][23:0]    thr;
        logic [3:0][31:0]    port;
        logic [3:0]          status;
        logic [3:0]          irq_en;
        logic                out_valid;
        logic [31:0]         out_word;
        logic                irq;
        logic [31:0]         prdata;
        logic                pready;
        logic                pslverr;
    } lcpf_state_s;

endpackage : lcpf_pkg

// >>> src/lcpf_top.sv
// four-channel load-cell post filter with step flush, apb registers and interrupt
// assumes conversions arrive on pclk from the decimation chain, at most one per cycle
//
// What this block does
// - four independent filter banks, one per transducer channel, fixed structure, selectable length.
// - conversions are 24-bit two's complement for filtering and threshold comparison.
// - tap length is a power of two from 1 to 1024; other lengths are refused.
// - each new conversion is compared against the filter's previous output.
// - a difference above threshold reloads the whole filter history with the new value.
// - threshold is a magnitude in raw adc counts.
// - default threshold follows the sampling rate, e.g. 268, 16, and 8 counts.
// - with auto-zero on, output arrives at about half the sampling rate.
// - excitation selects between the 2.5 V and 10 V source.
// - a flushing conversion sets bit 1 of its output word.
//
// The register addresses and the APB register port are this design's own decisions.
`include "lcpf_defines.svh"

module lcpf_top
(
    // clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // conversions from the decimation chain
    input  wire logic                  sample_valid,
    input  wire logic [1:0]            sample_chan,
    input  wire lcpf_pkg::lcpf_sample_t sample_data,
    // filtered stream towards the data fifo
    output logic                       out_valid,
    output logic      [31:0]           out_word,
    // excitation select and interrupt
    output logic                       exc_high,
    output logic                       irq
);
    import lcpf_pkg::*;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    lcpf_state_s s;
    lcpf_state_s next_s;

    logic        apb_setup;
    logic        apb_access;
    logic [3:0]  page;
    logic [1:0]  widx;
    logic        aligned;
    logic [23:0] x;
    logic [23:0] y;
    logic [24:0] diff;
    logic [24:0] mag;
    logic        exceed;
    logic        skip;
    logic        accept;
    logic [34:0] delta;
    logic [34:0] step;
    logic [33:0] acc_new;
    logic [3:0]  tap;
    logic [23:0] y_new;

    // codes 12 to 15 all fall back to the lowest threshold
    function automatic logic [23:0] default_thr(input logic [3:0] rate);
        unique case (rate)
            4'h0:    default_thr = `LCPF_THR_R0;
            4'h1:    default_thr = `LCPF_THR_R1;
            4'h2:    default_thr = `LCPF_THR_R2;
            4'h3:    default_thr = `LCPF_THR_R3;
            4'h4:    default_thr = `LCPF_THR_R4;
            4'h5:    default_thr = `LCPF_THR_R5;
            4'h6:    default_thr = `LCPF_THR_R6;
            4'h7:    default_thr = `LCPF_THR_R7;
            4'h8:    default_thr = `LCPF_THR_R8;
            4'h9:    default_thr = `LCPF_THR_R9;
            4'ha:    default_thr = `LCPF_THR_R10;
            4'hb:    default_thr = `LCPF_THR_R11;
            default: default_thr = `LCPF_THR_LOW;
        endcase
    endfunction : default_thr

    // pready high blocks a held setup from being taken twice
    assign apb_setup  = psel && !penable && !s.pready;
    assign apb_access = psel && penable && s.pready;
    assign page       = paddr[7:4];
    assign widx       = paddr[3:2];
    assign aligned    = (paddr[1:0] == 2'h0);

    // datapath for the channel that carries this cycle's conversion
    // ten fraction bits let a long tap still creep toward a small step
    assign tap     = s.taps[sample_chan];
    assign x       = sample_data;
    assign y       = s.acc[sample_chan][33:10];
    assign diff    = {x[23], x} - {y[23], y};
    assign mag     = diff[24] ? (25'h0 - diff) : diff;
    assign exceed  = (mag > {1'b0, s.thr[sample_chan]});
    // with auto-zero the odd phase is the zero reference and never reaches the filter
    assign skip    = s.az_en && s.az_phase[sample_chan];
    assign accept  = sample_valid && !skip;
    assign delta   = {x[23], x, 10'h000} - {s.acc[sample_chan][33], s.acc[sample_chan]};
    assign step    = $signed(delta) >>> tap;
    // a shift of zero makes step the full difference, so the result is the sample itself
    assign acc_new = (exceed || tap == 4'h0) ? {x, 10'h000}
                                             : s.acc[sample_chan] + step[33:0];
    assign y_new   = acc_new[33:10];

    always_comb
    begin
        next_s           = s;
        next_s.out_valid = 1'b0;
        // registered, so irq trails the status bits by one cycle
        next_s.irq       = |(s.status & s.irq_en);

        // apb: answer is prepared in setup and shown for exactly the access cycle
        if (apb_setup)
        begin
            next_s.pready  = 1'b1;
            next_s.pslverr = 1'b0;
            next_s.prdata  = 32'h0000_0000;
            if (!aligned)
                next_s.pslverr = 1'b1;
            else if (page == `LCPF_PAGE_THR)
                next_s.prdata = {8'h00, s.thr[widx]};
            else if (page == `LCPF_PAGE_PORT)
                next_s.prdata = s.port[widx];
            else
            begin
                unique case (paddr)
                    `LCPF_ADDR_CTRL:    next_s.prdata = {26'h0, s.exc_high, s.az_en, s.rate};
                    `LCPF_ADDR_TAPS:    next_s.prdata = {16'h0000, s.taps};
                    `LCPF_ADDR_STATUS:  next_s.prdata = {28'h0, s.status};
                    `LCPF_ADDR_IRQ_EN:  next_s.prdata = {28'h0, s.irq_en};
                    `LCPF_ADDR_IRQ_CLR: next_s.prdata = 32'h0000_0000;
                    default:            next_s.pslverr = 1'b1;
                endcase
            end
        end
        else if (apb_access)
        begin
            next_s.pready  = 1'b0;
            next_s.pslverr = 1'b0;
            // polling software sees bit 0 set only once per new word
            if (!pwrite && aligned && page == `LCPF_PAGE_PORT)
                next_s.port[widx][`LCPF_WORD_FRESH_BIT] = 1'b0;
            // the error is decided in setup, so a refused write never touches state
            if (pwrite && aligned && !s.pslverr)
            begin
                if (page == `LCPF_PAGE_THR)
                    next_s.thr[widx] = pwdata[23:0];
                else if (paddr == `LCPF_ADDR_CTRL)
                begin
                    next_s.rate     = pwdata[`LCPF_CTRL_RATE_LSB +: 4];
                    next_s.az_en    = pwdata[`LCPF_CTRL_AZ_BIT];
                    next_s.exc_high = pwdata[`LCPF_CTRL_EXC_BIT];
                    // a rate change overwrites hand-set thresholds; set them after the rate
                    for (int i = 0; i < 4; i++)
                        next_s.thr[i] = default_thr(pwdata[`LCPF_CTRL_RATE_LSB +: 4]);
                    if (!pwdata[`LCPF_CTRL_AZ_BIT])
                        next_s.az_phase = 4'h0;
                end
                else if (paddr == `LCPF_ADDR_TAPS)
                begin
                    // a field holding an unlisted length keeps its old value
                    for (int i = 0; i < 4; i++)
                        if (pwdata[i*`LCPF_TAP_FIELD_W +: 4] <= `LCPF_TAP_MAX)
                            next_s.taps[i] = pwdata[i*`LCPF_TAP_FIELD_W +: 4];
                end
                else if (paddr == `LCPF_ADDR_IRQ_EN)
                    next_s.irq_en = pwdata[3:0];
                else if (paddr == `LCPF_ADDR_IRQ_CLR)
                    next_s.status = s.status & ~pwdata[3:0];
            end
        end

        // conversions are handled after the bus so a new event beats a clear
        if (sample_valid && s.az_en)
            next_s.az_phase[sample_chan] = ~s.az_phase[sample_chan];
        if (accept)
        begin
            // only the addressed bank moves; the other three keep their history
            next_s.acc[sample_chan]  = acc_new;
            next_s.out_valid         = 1'b1;
            next_s.out_word          = {y_new, 2'h0, sample_chan, 2'h0, exceed, 1'b1};
            next_s.port[sample_chan] = {y_new, 2'h0, sample_chan, 2'h0, exceed, 1'b1};
            if (exceed)
                next_s.status[sample_chan] = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s          <= '0;
            s.rate     <= `LCPF_RST_RATE;
            s.taps     <= `LCPF_RST_TAPS;
            // thresholds start at the table entry of the reset rate
            s.thr[0]   <= `LCPF_THR_R8;
            s.thr[1]   <= `LCPF_THR_R8;
            s.thr[2]   <= `LCPF_THR_R8;
            s.thr[3]   <= `LCPF_THR_R8;
        end
        else
            s <= next_s;
    end

    assign prdata    = s.prdata;
    assign pready    = s.pready;
    assign pslverr   = s.pslverr;
    assign out_valid = s.out_valid;
    assign out_word  = s.out_word;
    assign exc_high  = s.exc_high;
    assign irq       = s.irq;

    chk_len_one_pass: assert property (
        accept && tap == 4'h0 |=> out_valid && out_word[31:8] == $past(sample_data))
        else $error("tap length one did not pass the sample through");

    chk_flush_reload: assert property (
        accept && exceed |=> out_word[`LCPF_WORD_FLUSH_BIT] && out_word[31:8] == $past(sample_data)
            ##1 s.acc[$past(sample_chan, 2)] == {$past(sample_data, 2), 10'h000} || $past(sample_valid))
        else $error("flush did not reload the filter with the new sample");

    chk_no_false_flush: assert property (
        accept && !exceed && tap != 4'h0 |=> !out_word[`LCPF_WORD_FLUSH_BIT])
        else $error("flush bit set without a step above threshold");

    chk_tap_range: assert property (
        s.taps[0] <= `LCPF_TAP_MAX && s.taps[1] <= `LCPF_TAP_MAX
            && s.taps[2] <= `LCPF_TAP_MAX && s.taps[3] <= `LCPF_TAP_MAX)
        else $error("tap length outside the allowed set");

    chk_rate_default: assert property (
        apb_access && pwrite && paddr == `LCPF_ADDR_CTRL && !s.pslverr
            |=> s.thr[2] == default_thr($past(pwdata[3:0])))
        else $error("threshold not reloaded from the rate table");

    chk_az_halving: assert property (
        sample_valid && s.az_en && s.az_phase[sample_chan] |=> !out_valid)
        else $error("auto-zero reference sample reached the output");

    chk_excitation: assert property (
        apb_access && pwrite && paddr == `LCPF_ADDR_CTRL && !s.pslverr
            |=> exc_high == $past(pwdata[`LCPF_CTRL_EXC_BIT]))
        else $error("excitation select did not follow the write");

    chk_irq_level: assert property (
        |(s.status & s.irq_en) |=> irq)
        else $error("enabled status bit did not raise the interrupt");

    chk_apb_answer: assert property (
        apb_setup |=> pready ##1 !pready)
        else $error("apb answer not exactly one access cycle");

    // stream, flag and register behaviour that software relies on
    chk_word_fields: assert property (
        accept |=> out_valid && out_word[`LCPF_WORD_FRESH_BIT] && out_word[5:4] == $past(sample_chan)
            && out_word[`LCPF_WORD_FLUSH_BIT] == ($past(mag) > {1'b0, $past(s.thr[sample_chan])}))
        else $error("output word fields do not match the conversion");

    chk_word_hold: assert property (
        !accept |=> $stable(out_word))
        else $error("output word changed without a new conversion");

    chk_idle_quiet: assert property (
        !sample_valid |=> !out_valid)
        else $error("output produced without a conversion");

    chk_port_copy: assert property (
        accept |=> s.port[$past(sample_chan)] == out_word)
        else $error("data port does not hold the latest word of its channel");

    chk_bank_apart: assert property (
        accept |=> s.acc[$past(sample_chan) + 2'h1] == $past(s.acc[sample_chan + 2'h1]))
        else $error("a conversion disturbed another channel filter");

    chk_fresh_clear: assert property (
        apb_access && !pwrite && aligned && page == `LCPF_PAGE_PORT && !(accept && sample_chan == widx)
            |=> !s.port[$past(widx)][`LCPF_WORD_FRESH_BIT])
        else $error("reading a data port did not clear its fresh bit");

    chk_status_set: assert property (
        accept && exceed |=> s.status[$past(sample_chan)])
        else $error("flush event did not set its status bit");

    chk_status_sticky: assert property (
        !(apb_access && pwrite && paddr == `LCPF_ADDR_IRQ_CLR)
            |=> (s.status & $past(s.status)) == $past(s.status))
        else $error("status bit fell without a clear write");

    chk_irq_quiet: assert property (
        !(|(s.status & s.irq_en)) |=> !irq)
        else $error("interrupt high with no enabled status bit");

    chk_err_unaligned: assert property (
        apb_setup && !aligned |=> pready && pslverr && prdata == 32'h0000_0000)
        else $error("unaligned access not refused");

    chk_pready_origin: assert property (
        $rose(pready) |-> $past(apb_setup))
        else $error("bus answer without a setup cycle");

    chk_thr_write: assert property (
        apb_access && pwrite && aligned && page == `LCPF_PAGE_THR && !s.pslverr
            |=> s.thr[$past(widx)] == $past(pwdata[23:0]))
        else $error("threshold write did not land");

    chk_tap_write: assert property (
        apb_access && pwrite && paddr == `LCPF_ADDR_TAPS && !s.pslverr && pwdata[15:12] <= `LCPF_TAP_MAX
            |=> s.taps[3] == $past(pwdata[15:12]))
        else $error("listed tap length was not taken");

    chk_tap_refused: assert property (
        apb_access && pwrite && paddr == `LCPF_ADDR_TAPS && !s.pslverr && pwdata[11:8] > `LCPF_TAP_MAX
            |=> s.taps[2] == $past(s.taps[2]))
        else $error("unlisted tap length was accepted");

    chk_rate_write: assert property (
        apb_access && pwrite && paddr == `LCPF_ADDR_CTRL && !s.pslverr
            |=> s.rate == $past(pwdata[3:0]) && s.az_en == $past(pwdata[`LCPF_CTRL_AZ_BIT]))
        else $error("control write did not land");

    chk_az_keep: assert property (
        sample_valid && s.az_en && !s.az_phase[sample_chan] |=> out_valid)
        else $error("auto-zero dropped a measuring conversion");

    chk_az_restart: assert property (
        apb_access && pwrite && paddr == `LCPF_ADDR_CTRL && !s.pslverr && !pwdata[`LCPF_CTRL_AZ_BIT]
            && !sample_valid |=> s.az_phase == 4'h0)
        else $error("auto-zero phase not restarted");

    chk_exc_hold: assert property (
        !(apb_access && pwrite && paddr == `LCPF_ADDR_CTRL) |=> $stable(exc_high))
        else $error("excitation select changed without a write");

endmodule : lcpf_top

// >>> bench/lcpf_adc_model.sv
// conversion source standing in for the decimation and auto-zero chain
// assumes pclk from the bench; one conversion per send call, driven just after a rising edge
module lcpf_adc_model
(
    // clock
    input  wire logic                   pclk,
    // conversion stream
    output logic                        sample_valid,
    output logic [1:0]                  sample_chan,
    output lcpf_pkg::lcpf_sample_t      sample_data
);
    timeunit 1ns;
    timeprecision 1ns;
    import lcpf_pkg::*;

    initial
    begin
        sample_valid = 1'b0;
        sample_chan  = 2'h0;
        sample_data  = 24'h000000;
    end

    // gap gives slow delivery; after the pulse the data lines show the inverse so a stale value never passes
    task automatic send(input logic [1:0] ch, input lcpf_sample_t d, input int gap);
        repeat (gap) @(posedge pclk);
        @(posedge pclk);
        sample_valid <= 1'b1;
        sample_chan  <= ch;
        sample_data  <= d;
        @(posedge pclk);
        sample_valid <= 1'b0;
        sample_data  <= ~d;
    endtask : send
endmodule : lcpf_adc_model

// >>> bench/testbench.sv
// self-checking bench for the four-channel load-cell post filter
// assumes lcpf_top with its apb slave and the conversion source model
`include "lcpf_defines.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ns;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        sample_valid, out_valid, exc_high, irq, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, out_word, last_word, rd;
    logic [1:0]  sample_chan;
    logic [23:0] sample_data;
    int          n_fail, checked, n_out, cycles;
    logic [23:0] thr_tab [16] = '{`LCPF_THR_R0, `LCPF_THR_R1, `LCPF_THR_R2, `LCPF_THR_R3, `LCPF_THR_R4,
        `LCPF_THR_R5, `LCPF_THR_R6, `LCPF_THR_R7, `LCPF_THR_R8, `LCPF_THR_R9, `LCPF_THR_R10,
        `LCPF_THR_R11, `LCPF_THR_LOW, `LCPF_THR_LOW, `LCPF_THR_LOW, `LCPF_THR_LOW};

    lcpf_top i_lcpf_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sample_valid(sample_valid), .sample_chan(sample_chan), .sample_data(sample_data),
        .out_valid(out_valid), .out_word(out_word), .exc_high(exc_high), .irq(irq));
    lcpf_adc_model i_lcpf_adc_model (.pclk(pclk), .sample_valid(sample_valid), .sample_chan(sample_chan),
        .sample_data(sample_data));

    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        cycles <= cycles + 1;
        if (out_valid === 1'b1)
        begin
            n_out     <= n_out + 1;
            last_word <= out_word;
        end
        // the whole run needs well under a thousand cycles
        if (cycles == 5000)
        begin
            n_fail = n_fail + 1;
            complete_run();
        end
    end

    task automatic complete_run;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // request stands until the rising edge that samples pready high; the answer is taken there
        do @(posedge pclk); while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic conv(input logic [1:0] ch, input logic [23:0] d, input logic [23:0] y, input logic f);
        i_lcpf_adc_model.send(ch, d, 0);
        repeat (2) @(negedge pclk);
        chk(last_word, {y, 2'b00, ch, 2'b00, f, 1'b1});
    endtask : conv

    task automatic chk_irq(input logic exp);
        repeat (2) @(negedge pclk);
        chk({31'h0, irq}, {31'h0, exp});
    endtask : chk_irq

    task automatic t_rates;
        apb(1'b0, `LCPF_ADDR_CTRL, 32'h0);
        chk(rd, 32'h8);
        apb(1'b0, 8'h14, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000);
        for (int r = 0; r < 16; r++)
        begin
            apb(1'b1, `LCPF_ADDR_CTRL, {26'h0, r[0], 1'b0, r[3:0]});
            apb(1'b0, {`LCPF_PAGE_THR, 4'hc}, 32'h0);
            chk(rd, {8'h00, thr_tab[r]});
            chk({31'h0, exc_high}, {31'h0, r[0]});
        end
        // sixty samples a second to sit in the notch of sixty hertz mains
        apb(1'b1, `LCPF_ADDR_CTRL, 32'h08);
        apb(1'b1, `LCPF_ADDR_TAPS, 32'h0000ab20);
        apb(1'b0, `LCPF_ADDR_TAPS, 32'h0);
        chk(rd, 32'h0000a020);
    endtask : t_rates

    task automatic t_filter;
        conv(2'd0, 24'hfffff8, 24'hfffff8, 1'b0);
        apb(1'b1, {`LCPF_PAGE_THR, 4'h0}, 32'h100);
        conv(2'd0, 24'h0000f8, 24'h0000f8, 1'b0);
        conv(2'd0, 24'h0001f9, 24'h0001f9, 1'b1);
        apb(1'b0, {`LCPF_PAGE_PORT, 4'h0}, 32'h0);
        chk(rd, 32'h0001f903);
        apb(1'b0, {`LCPF_PAGE_PORT, 4'h0}, 32'h0);
        chk(rd, 32'h0001f902);
        conv(2'd1, 24'd1000, 24'd1000, 1'b1);
        conv(2'd1, 24'd1008, 24'd1002, 1'b0);
        conv(2'd1, 24'd1300, 24'd1300, 1'b1);
        conv(2'd1, 24'd1292, 24'd1298, 1'b0);
    endtask : t_filter

    task automatic t_autozero;
        int n0;
        apb(1'b1, `LCPF_ADDR_CTRL, 32'h18);
        n0 = n_out;
        for (int k = 0; k < 4; k++)
            i_lcpf_adc_model.send(2'd2, 24'(k), k);
        repeat (2) @(negedge pclk);
        chk(32'(n_out - n0), 32'h2);
        chk(last_word, 32'h0000_0221);
        apb(1'b1, `LCPF_ADDR_CTRL, 32'h08);
    endtask : t_autozero

    task automatic t_irq;
        apb(1'b0, `LCPF_ADDR_STATUS, 32'h0);
        chk(rd, 32'h3);
        apb(1'b1, `LCPF_ADDR_IRQ_CLR, 32'hf);
        apb(1'b1, `LCPF_ADDR_STATUS, 32'hf);
        apb(1'b0, `LCPF_ADDR_STATUS, 32'h0);
        chk(rd, 32'h0);
        conv(2'd3, 24'h000200, 24'h000200, 1'b1);
        conv(2'd3, 24'h00020a, 24'h000200, 1'b0);
        chk_irq(1'b0);
        apb(1'b1, `LCPF_ADDR_IRQ_EN, 32'h8);
        chk_irq(1'b1);
        apb(1'b1, `LCPF_ADDR_IRQ_CLR, 32'h8);
        chk_irq(1'b0);
        apb(1'b0, 8'h02, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000);
    endtask : t_irq

    initial
    begin
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
        n_fail  = 0;
        checked = 0;
        n_out   = 0;
        cycles  = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_rates();
        t_filter();
        t_autozero();
        t_irq();
        complete_run();
    end
endmodule : testbench
